//--- logic/mrc_pkg.sv
// constants and types for the remote command interpreter
// assumes one 25 MHz clock and an APB master with 32-bit data
package mrc_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TALK = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_MVAL = 8'h10;
  localparam logic [7:0] OFS_MAUX = 8'h14;
  // status and read-data field positions
  localparam int ST_TXV = 0;
  localparam int ST_RDY = 1;
  localparam int ST_PEND = 2;
  localparam int ST_CBAD = 3;
  localparam int ST_OBAD = 4;
  localparam int ST_PASS = 5;
  localparam int ST_PFX = 6;
  localparam int TXD_VLD = 8;
  localparam int AUX_UNIT = 8;
  localparam int AUX_FLAG = 16;
  // ********************************
  // timing
  // ********************************
  localparam int unsigned CLK_HZ = 25_000_000;
  // fastest reading rate in tenths of readings per second
  localparam int unsigned READ_RATE_X10 = 24;
  localparam int unsigned READ_GAP_CYC = (CLK_HZ * 10 + READ_RATE_X10 - 1) / READ_RATE_X10;
  // ********************************
  // characters and words
  // ********************************
  localparam int BUF_LEN = 20;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [39:0] VAL_UNDER = 40'h20_2E_30_30_30;
  localparam logic [39:0] VAL_OVER = 40'h31_39_39_2E_39;
  // identity header, software and hardware revisions: arbitrary values
  localparam logic [31:0] HDR_ID = 32'h31_30_30_30;
  localparam logic [15:0] SW_REV = 16'h3031;
  localparam logic [15:0] HW_REV = 16'h3031;
  // ********************************
  // types and reset values
  // ********************************
  typedef enum logic [2:0] {
    M_FWD, M_FWD_LOG, M_REF, M_REF_LOG, M_SWR, M_RLOSS, M_MIN, M_MAX
  } mrc_meas_t;
  typedef enum logic [1:0] {TR_CONT, TR_KEY, TR_BUS, TR_CMD} mrc_trig_t;
  typedef enum logic [1:0] {TM_CRLF, TM_CR, TM_NONE} mrc_term_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_READ, SRC_MACH, SRC_ERR, SRC_REV} mrc_src_t;
  typedef enum logic [1:0] {PS_IDLE, PS_OPT, PS_RANGE, PS_STORE} mrc_pst_t;
  typedef enum logic [1:0] {FL_NORM, FL_UNDER, FL_OVER} mrc_flag_t;
  localparam logic PREFIX_RST = 1'b0;
  localparam mrc_trig_t TRIG_RST = TR_CONT;
  localparam mrc_term_t TERM_RST = TM_CRLF;
  localparam mrc_meas_t MEAS_RST = M_FWD;
endpackage : mrc_pkg

//--- logic/mrc_top.sv
// remote command interpreter: parses command characters, keeps
// settings, error and self-test flags, and formats reply strings
// assumes an APB master, pins from outside the clock domain, and
// self-test and front-panel logic on the same clock
module mrc_top #(
  parameter int unsigned READ_GAP = mrc_pkg::READ_GAP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic key_enter,
  input wire logic bus_trig,
  input wire logic iface_serial,
  // front panel
  input wire logic panel_load,
  input wire logic panel_prefix,
  input wire logic [1:0] panel_trig,
  input wire logic [2:0] panel_meas,
  input wire logic [1:0] panel_term,
  // self-test engine
  input wire logic selftest_done,
  input wire logic selftest_pass,
  output logic selftest_start,
  // active settings and reading strobe
  output logic prefix_on,
  output logic [1:0] trig_mode,
  output logic [2:0] meas_type,
  output logic [1:0] term_mode,
  output logic reading_strobe
);
  // ********************************
  // functions
  // ********************************
  function automatic logic opt_ok(input logic [7:0] l, input logic [7:0] c);
    unique case (l)
      8'h50: opt_ok = (c == 8'h59) || (c == 8'h4E);
      8'h54: opt_ok = (c == 8'h30) || (c == 8'h31) || (c == 8'h33) || (c == 8'h35);
      8'h55: opt_ok = (c >= 8'h30) && (c <= 8'h32);
      8'h4A: opt_ok = (c == 8'h30);
      8'h59: opt_ok = (c == 8'h54) || (c == 8'h4F) || (c == 8'h4E);
      8'h52: opt_ok = (c == 8'h43) || (c == 8'h44) || (c == 8'h4C) || (c == 8'h59)
          || (c == 8'h4E) || (c == 8'h30) || (c == 8'h31);
      8'h46: opt_ok = (c == 8'h43) || (c == 8'h44);
      8'h53: opt_ok = (c == 8'h57);
      8'h4D: opt_ok = (c == 8'h4E) || (c == 8'h58);
      default: opt_ok = 1'b0;
    endcase
  endfunction : opt_ok

  // {hit, type} for a two-letter measurement command
  function automatic logic [3:0] meas_dec(input logic [7:0] l, input logic [7:0] c);
    unique case ({l, c})
      16'h4643: meas_dec = {1'b1, mrc_pkg::M_FWD};
      16'h4644: meas_dec = {1'b1, mrc_pkg::M_FWD_LOG};
      16'h5243: meas_dec = {1'b1, mrc_pkg::M_REF};
      16'h5244: meas_dec = {1'b1, mrc_pkg::M_REF_LOG};
      16'h5357: meas_dec = {1'b1, mrc_pkg::M_SWR};
      16'h524C: meas_dec = {1'b1, mrc_pkg::M_RLOSS};
      16'h4D4E: meas_dec = {1'b1, mrc_pkg::M_MIN};
      16'h4D58: meas_dec = {1'b1, mrc_pkg::M_MAX};
      default: meas_dec = 4'h0;
    endcase
  endfunction : meas_dec

  function automatic logic [15:0] meas_code(input logic [2:0] m);
    unique case (m)
      mrc_pkg::M_FWD: meas_code = 16'h4643;
      mrc_pkg::M_FWD_LOG: meas_code = 16'h4644;
      mrc_pkg::M_REF: meas_code = 16'h5243;
      mrc_pkg::M_REF_LOG: meas_code = 16'h5244;
      mrc_pkg::M_SWR: meas_code = 16'h5357;
      mrc_pkg::M_RLOSS: meas_code = 16'h524C;
      mrc_pkg::M_MIN: meas_code = 16'h4D4E;
      default: meas_code = 16'h4D58;
    endcase
  endfunction : meas_code

  function automatic logic [7:0] term_char(input logic [1:0] t);
    unique case (t)
      mrc_pkg::TM_CRLF: term_char = 8'h54;
      mrc_pkg::TM_CR: term_char = 8'h4F;
      default: term_char = 8'h4E;
    endcase
  endfunction : term_char

  // ********************************
  // pin synchronisers
  // ********************************
  logic [2:0] key_s_q;
  logic [2:0] trg_s_q;
  logic [1:0] ifc_s_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s_q <= 3'h0;
      trg_s_q <= 3'h0;
      ifc_s_q <= 2'h0;
    end else begin
      key_s_q <= {key_s_q[1:0], key_enter};
      trg_s_q <= {trg_s_q[1:0], bus_trig};
      ifc_s_q <= {ifc_s_q[0], iface_serial};
    end
  end
  wire key_edge = key_s_q[1] & ~key_s_q[2];
  wire trg_edge = trg_s_q[1] & ~trg_s_q[2];

  // ********************************
  // apb slave
  // ********************************
  // one wait state: pready rises in the second access cycle
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_w;
  wire acc = psel & penable & pready_q;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire ack_d = psel & penable & ~pready_q;
  wire hit_cmd = paddr == mrc_pkg::OFS_CMD;
  wire hit_talk = paddr == mrc_pkg::OFS_TALK;
  wire hit_txd = paddr == mrc_pkg::OFS_TXD;
  wire hit_stat = paddr == mrc_pkg::OFS_STAT;
  wire hit_mval = paddr == mrc_pkg::OFS_MVAL;
  wire hit_maux = paddr == mrc_pkg::OFS_MAUX;
  wire mapped = hit_cmd | hit_talk | hit_txd | hit_stat | hit_mval | hit_maux;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= ack_d;
      pslverr_q <= ack_d & ~mapped;
      if (ack_d) begin
        prdata_q <= pwrite ? 32'h0 : rdata_w;
      end
    end
  end

  // ********************************
  // command parser
  // ********************************
  mrc_pkg::mrc_pst_t pst_q;
  logic [7:0] lead_q;
  logic [2:0] cnt_q;
  logic [7:0] sc_q [0:5];
  wire [7:0] ch = pwdata[7:0];
  wire cmd_wr = wr_acc & hit_cmd;
  wire is_ws = (ch == mrc_pkg::CH_SP) || (ch == mrc_pkg::CH_CR)
      || (ch == mrc_pkg::CH_LF) || (ch == 8'h2C);
  wire lead_ok = (ch == 8'h57) || opt_ok(ch, 8'h30) || opt_ok(ch, 8'h43)
      || opt_ok(ch, 8'h57) || opt_ok(ch, 8'h4E);
  wire in_idle = cmd_wr & (pst_q == mrc_pkg::PS_IDLE) & ~is_ws;
  wire ev_opt = cmd_wr & (pst_q == mrc_pkg::PS_OPT);
  wire good = opt_ok(lead_q, ch);
  wire [3:0] md = meas_dec(lead_q, ch);
  wire ev_cbad = in_idle & ~lead_ok;
  wire ev_obad = ev_opt & ~good;
  wire ev_ok = ev_opt & good;
  wire set_p = ev_ok & (lead_q == 8'h50);
  wire set_t = ev_ok & (lead_q == 8'h54);
  wire set_y = ev_ok & (lead_q == 8'h59);
  wire set_u = ev_ok & (lead_q == 8'h55);
  wire set_j = ev_ok & (lead_q == 8'h4A);
  wire set_m = ev_ok & md[3];
  wire to_range = ev_ok & (lead_q == 8'h52) & ~md[3];
  wire restore = set_u & (ch == 8'h30);
  wire [1:0] trig_new = (ch == 8'h30) ? mrc_pkg::TR_CONT : (ch == 8'h31) ? mrc_pkg::TR_KEY
      : (ch == 8'h33) ? mrc_pkg::TR_BUS : mrc_pkg::TR_CMD;
  wire [1:0] term_new = (ch == 8'h54) ? mrc_pkg::TM_CRLF
      : (ch == 8'h4F) ? mrc_pkg::TM_CR : mrc_pkg::TM_NONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_q <= mrc_pkg::PS_IDLE;
      lead_q <= 8'h0;
      cnt_q <= 3'h0;
    end else if (cmd_wr) begin
      unique case (pst_q)
        mrc_pkg::PS_IDLE: begin
          lead_q <= ch;
          cnt_q <= 3'h0;
          if (!is_ws && lead_ok) begin
            pst_q <= (ch == 8'h57) ? mrc_pkg::PS_STORE : mrc_pkg::PS_OPT;
          end
        end
        mrc_pkg::PS_OPT: begin
          pst_q <= to_range ? mrc_pkg::PS_RANGE : mrc_pkg::PS_IDLE;
        end
        // range value itself is handled by the measurement chain
        mrc_pkg::PS_RANGE: begin
          pst_q <= mrc_pkg::PS_IDLE;
        end
        mrc_pkg::PS_STORE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h5) begin
            pst_q <= mrc_pkg::PS_IDLE;
          end
        end
      endcase
    end
  end

  // six scratch bytes, lost at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q <= '{default: mrc_pkg::CH_SP};
    end else if (cmd_wr && pst_q == mrc_pkg::PS_STORE) begin
      sc_q[cnt_q] <= ch;
    end
  end

  // ********************************
  // settings
  // ********************************
  // remote copy survives panel changes so a machine query can restore it
  logic rem_pfx_q;
  logic act_pfx_q;
  logic [1:0] rem_trg_q;
  logic [1:0] act_trg_q;
  logic [1:0] rem_trm_q;
  logic [1:0] act_trm_q;
  logic [2:0] rem_mea_q;
  logic [2:0] act_mea_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_pfx_q <= mrc_pkg::PREFIX_RST;
      act_pfx_q <= mrc_pkg::PREFIX_RST;
      rem_trg_q <= mrc_pkg::TRIG_RST;
      act_trg_q <= mrc_pkg::TRIG_RST;
      rem_trm_q <= mrc_pkg::TERM_RST;
      act_trm_q <= mrc_pkg::TERM_RST;
      rem_mea_q <= mrc_pkg::MEAS_RST;
      act_mea_q <= mrc_pkg::MEAS_RST;
    end else if (ev_ok) begin
      if (set_p) begin
        rem_pfx_q <= ch == 8'h59;
        act_pfx_q <= ch == 8'h59;
      end
      if (set_t) begin
        rem_trg_q <= trig_new;
        act_trg_q <= trig_new;
      end
      if (set_y) begin
        rem_trm_q <= term_new;
        act_trm_q <= term_new;
      end
      if (set_m) begin
        rem_mea_q <= md[2:0];
        act_mea_q <= md[2:0];
      end
      if (restore) begin
        act_pfx_q <= rem_pfx_q;
        act_trg_q <= rem_trg_q;
        act_trm_q <= rem_trm_q;
        act_mea_q <= rem_mea_q;
      end
    end else if (panel_load) begin
      act_pfx_q <= panel_prefix;
      act_trg_q <= panel_trig;
      act_trm_q <= panel_term;
      act_mea_q <= panel_meas;
    end
  end

  // ********************************
  // triggers and readings
  // ********************************
  logic cont_q;
  logic armed_q;
  logic [23:0] gap_q;
  logic [31:0] mval_q;
  logic [17:0] maux_q;
  logic [39:0] rd_val_q;
  logic [7:0] rd_unit_q;
  logic [1:0] rd_flag_q;
  logic [2:0] rd_mea_q;
  logic rd_vld_q;
  logic strobe_q;
  logic talk_rd;
  wire mode_chg = set_t | restore | panel_load;
  wire arm = (key_edge & (act_trg_q == mrc_pkg::TR_KEY))
      | (trg_edge & (act_trg_q == mrc_pkg::TR_BUS))
      | (set_m & (act_trg_q == mrc_pkg::TR_CMD));
  // readings spaced by at least the fastest period
  wire take = (cont_q | armed_q) & (gap_q == 24'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_q <= 1'b0;
      armed_q <= 1'b0;
      gap_q <= 24'h0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= take;
      if (mode_chg) begin
        cont_q <= 1'b0;
        armed_q <= 1'b0;
      end else begin
        cont_q <= cont_q | (key_edge & (act_trg_q == mrc_pkg::TR_CONT));
        armed_q <= arm | (armed_q & ~take);
      end
      if (take) begin
        gap_q <= 24'(READ_GAP - 1);
      end else if (gap_q != 24'h0) begin
        gap_q <= gap_q - 24'h1;
      end
    end
  end

  // no reading until a trigger has fired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mval_q <= 32'h0;
      maux_q <= 18'h0;
      rd_val_q <= 40'h0;
      rd_unit_q <= 8'h0;
      rd_flag_q <= mrc_pkg::FL_NORM;
      rd_mea_q <= mrc_pkg::MEAS_RST;
      rd_vld_q <= 1'b0;
    end else begin
      if (wr_acc && hit_mval) begin
        mval_q <= pwdata;
      end
      if (wr_acc && hit_maux) begin
        maux_q <= pwdata[17:0];
      end
      if (take) begin
        rd_val_q <= {mval_q, maux_q[7:0]};
        rd_unit_q <= maux_q[mrc_pkg::AUX_UNIT +: 8];
        rd_flag_q <= maux_q[mrc_pkg::AUX_FLAG +: 2];
        rd_mea_q <= act_mea_q;
      end
      rd_vld_q <= take | (rd_vld_q & ~talk_rd);
    end
  end

  // ********************************
  // flags and status selection
  // ********************************
  logic pend_q;
  logic [1:0] sel_q;
  logic cbad_q;
  logic obad_q;
  logic pass_q;
  logic st_q;
  logic err_sent;
  logic talk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      sel_q <= 2'h0;
      cbad_q <= 1'b0;
      obad_q <= 1'b0;
      pass_q <= 1'b0;
      st_q <= 1'b0;
    end else begin
      // status word waits for next talk
      pend_q <= set_u | (pend_q & ~talk);
      if (set_u) begin
        sel_q <= ch[1:0];
      end
      // clear after error word, new error wins
      cbad_q <= ev_cbad | (cbad_q & ~err_sent);
      obad_q <= ev_obad | (obad_q & ~err_sent);
      st_q <= set_j;
      // fail unless a run just passed
      if (selftest_done && selftest_pass) begin
        pass_q <= 1'b1;
      end else if (set_j || selftest_done || err_sent) begin
        pass_q <= 1'b0;
      end
    end
  end

  // ********************************
  // reply assembly
  // ********************************
  logic [7:0] s [0:mrc_pkg::BUF_LEN-1];
  logic [4:0] len_w;
  mrc_pkg::mrc_src_t src_w;
  wire [15:0] rcode = meas_code(rd_mea_q);
  wire [15:0] acode = meas_code(act_mea_q);
  // substitute value and pick status letter
  wire [39:0] val_w = (rd_flag_q == mrc_pkg::FL_UNDER) ? mrc_pkg::VAL_UNDER
      : (rd_flag_q == mrc_pkg::FL_OVER) ? mrc_pkg::VAL_OVER : rd_val_q;
  wire [7:0] flag_ch = (rd_flag_q == mrc_pkg::FL_UNDER) ? 8'h55
      : (rd_flag_q == mrc_pkg::FL_OVER) ? 8'h4F : 8'h4E;
  assign src_w = pend_q ? ((sel_q == 2'h0) ? mrc_pkg::SRC_MACH
      : (sel_q == 2'h1) ? mrc_pkg::SRC_ERR : mrc_pkg::SRC_REV)
      : rd_vld_q ? mrc_pkg::SRC_READ : mrc_pkg::SRC_NONE;

  always_comb begin
    int n;
    n = 0;
    s = '{default: mrc_pkg::CH_SP};
    if (src_w != mrc_pkg::SRC_READ && src_w != mrc_pkg::SRC_NONE) begin
      for (int i = 0; i < 4; i++) s[i] = mrc_pkg::HDR_ID[31-8*i -: 8];
      n = 4;
    end
    unique case (src_w)
      mrc_pkg::SRC_READ: begin
        // prefix letter and type code first
        if (act_pfx_q) begin
          s[0] = flag_ch;
          s[1] = rcode[15:8];
          s[2] = rcode[7:0];
          n = 3;
        end
        for (int i = 0; i < 5; i++) s[n+i] = val_w[39-8*i -: 8];
        s[n+5] = rd_unit_q;
        n = n + 6;
      end
      mrc_pkg::SRC_MACH: begin
        s[4] = act_pfx_q ? 8'h59 : 8'h4E;
        // trigger digits are 0 1 3 5, not the encoding
        s[5] = (act_trg_q == mrc_pkg::TR_CONT) ? 8'h30 : (act_trg_q == mrc_pkg::TR_KEY) ? 8'h31
            : (act_trg_q == mrc_pkg::TR_BUS) ? 8'h33 : 8'h35;
        s[6] = acode[15:8];
        s[7] = acode[7:0];
        s[8] = term_char(act_trm_q);
        n = 9;
      end
      mrc_pkg::SRC_ERR: begin
        s[4] = cbad_q ? 8'h49 : 8'h56;
        s[5] = 8'h43;
        s[6] = 8'h4D;
        s[7] = obad_q ? 8'h49 : 8'h56;
        s[8] = 8'h43;
        s[9] = 8'h4F;
        s[10] = pass_q ? 8'h50 : 8'h46;
        s[11] = pass_q ? 8'h53 : 8'h4C;
        n = 12;
      end
      mrc_pkg::SRC_REV: begin
        for (int i = 0; i < 6; i++) s[4+i] = sc_q[i];
        s[10] = mrc_pkg::SW_REV[15:8];
        s[11] = mrc_pkg::SW_REV[7:0];
        s[12] = mrc_pkg::HW_REV[15:8];
        s[13] = mrc_pkg::HW_REV[7:0];
        s[14] = ifc_s_q[1] ? 8'h53 : 8'h47;
        s[15] = term_char(act_trm_q);
        n = 16;
      end
      default: n = 0;
    endcase
    if (src_w != mrc_pkg::SRC_NONE && act_trm_q != mrc_pkg::TM_NONE) begin
      s[n] = mrc_pkg::CH_CR;
      n = n + 1;
      if (act_trm_q == mrc_pkg::TM_CRLF) begin
        s[n] = mrc_pkg::CH_LF;
        n = n + 1;
      end
    end
    len_w = 5'(n);
  end

  // ********************************
  // talker buffer
  // ********************************
  logic [7:0] buf_q [0:mrc_pkg::BUF_LEN-1];
  logic [4:0] len_q;
  logic [4:0] idx_q;
  mrc_pkg::mrc_src_t kind_q;
  assign talk = wr_acc & hit_talk;
  assign talk_rd = talk & ~pend_q;
  wire tx_v = idx_q < len_q;
  wire pop = rd_acc & hit_txd & tx_v;
  assign err_sent = pop & (idx_q == len_q - 5'h1) & (kind_q == mrc_pkg::SRC_ERR);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= '{default: 8'h00};
      len_q <= 5'h0;
      idx_q <= 5'h0;
      kind_q <= mrc_pkg::SRC_NONE;
    end else if (talk) begin
      buf_q <= s;
      len_q <= len_w;
      idx_q <= 5'h0;
      kind_q <= src_w;
    end else if (pop) begin
      idx_q <= idx_q + 5'h1;
    end
  end

  wire [31:0] stat_w = {25'h0, act_pfx_q, pass_q, obad_q, cbad_q, pend_q, rd_vld_q, tx_v};
  wire [31:0] txd_w = {23'h0, tx_v, tx_v ? buf_q[idx_q] : 8'h00};
  assign rdata_w = hit_stat ? stat_w : hit_txd ? txd_w : hit_mval ? mval_q
      : hit_maux ? {14'h0, maux_q} : 32'h0;

  // ********************************
  // outputs
  // ********************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign selftest_start = st_q;
  assign prefix_on = act_pfx_q;
  assign trig_mode = act_trg_q;
  assign meas_type = act_mea_q;
  assign term_mode = act_trm_q;
  assign reading_strobe = strobe_q;
endmodule : mrc_top

//--- dv/mrc_chk.sv
// checker for the apb side and the settings outputs of mrc_top
// bound to mrc_top, single clock domain
module mrc_chk (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic panel_load, selftest_start, prefix_on, reading_strobe,
  input wire logic [1:0] trig_mode, term_mode,
  input wire logic [2:0] meas_type
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_cmd = psel && penable && pready && pwrite && (paddr == mrc_pkg::OFS_CMD);
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= mrc_pkg::OFS_MAUX);
  // history of the two setting sources over the last two edges
  logic wr_cmd_q1, wr_cmd_q2, load_q1, load_q2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cmd_q1 <= 1'b0;
      wr_cmd_q2 <= 1'b0;
      load_q1 <= 1'b0;
      load_q2 <= 1'b0;
    end else begin
      wr_cmd_q1 <= wr_cmd;
      wr_cmd_q2 <= wr_cmd_q1;
      load_q1 <= panel_load;
      load_q2 <= load_q1;
    end
  end
  wire src = wr_cmd_q1 || wr_cmd_q2 || load_q1 || load_q2;
  // ****
  // properties
  // ****
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pready |-> (pslverr == !mapped); endproperty
  a_err: assert property (p_err) else $error("pslverr does not match address map");
  property p_rst; $rose(presetn) |-> !prefix_on && trig_mode == 2'h0 && meas_type == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("settings not at reset values");
  property p_pfx; $changed(prefix_on) |-> src; endproperty
  a_pfx: assert property (p_pfx) else $error("prefix changed without cause");
  property p_trig; $changed(trig_mode) || $changed(term_mode) |-> src; endproperty
  a_trig: assert property (p_trig) else $error("mode changed without cause");
  property p_term; term_mode != 2'h3; endproperty
  a_term: assert property (p_term) else $error("terminator mode out of range");
  property p_st; selftest_start |-> ($past(wr_cmd) || $past(wr_cmd, 2)) ##1 !selftest_start;
  endproperty
  a_st: assert property (p_st) else $error("self-test start not a pulse");
  property p_rate; reading_strobe |=> !reading_strobe [*8]; endproperty
  a_rate: assert property (p_rate) else $error("readings too close");
  c_err: cover property (pready && pslverr);
  c_st: cover property (selftest_start);
  c_rd: cover property (reading_strobe);
endmodule : mrc_chk

bind mrc_top mrc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .panel_load(panel_load),
  .selftest_start(selftest_start), .prefix_on(prefix_on), .reading_strobe(reading_strobe),
  .trig_mode(trig_mode), .term_mode(term_mode), .meas_type(meas_type));

//--- dv/mrc_st_model.sv
// self-test engine model: done pulse three cycles after each start
// result comes from pass_in, set by the bench beforehand
module mrc_st_model (
  input wire logic pclk, presetn, selftest_start, pass_in,
  output logic selftest_done, selftest_pass
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dly_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dly_q <= 3'h0;
    else dly_q <= {dly_q[1:0], selftest_start};
  end
  assign selftest_done = dly_q[2];
  // result unqualified outside done: show the wrong level
  assign selftest_pass = dly_q[2] ? pass_in : !pass_in;
endmodule : mrc_st_model

//--- dv/testbench.sv
// testbench: command strings over apb, replies read back and compared
// assumes the bound checker and the self-test engine model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bus_trig = 0, panel_load = 0, pnl_pfx = 0, key_pin = 0, st_pass_in = 1;
  logic st_done, st_pass, selftest_start, prefix_on, reading_strobe;
  logic [1:0] trig_mode, term_mode;
  logic [2:0] meas_type;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  string s;
  initial forever #20 pclk = ~pclk;
  mrc_top #(.READ_GAP(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_enter(key_pin), .bus_trig(bus_trig),
    .iface_serial(1'b0), .panel_load(panel_load), .panel_prefix(pnl_pfx),
    .panel_trig(2'h0), .panel_meas(3'h0), .panel_term(2'h0), .selftest_done(st_done),
    .selftest_pass(st_pass), .selftest_start(selftest_start), .prefix_on(prefix_on),
    .trig_mode(trig_mode), .meas_type(meas_type), .term_mode(term_mode),
    .reading_strobe(reading_strobe));
  mrc_st_model st_u (.pclk(pclk), .presetn(presetn), .selftest_start(selftest_start),
    .pass_in(st_pass_in), .selftest_done(st_done), .selftest_pass(st_pass));
  // ****
  // tasks
  // ****
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_s(input string nm, input string e, input string g);
    cmp_count++;
    if (g != e) begin
      n_fail++;
      $display("[ERR] %s exp %s got %s", nm, e, g);
    end
  endtask : chk_s
  task automatic cmd(input string c);
    foreach (c[i]) apb(mrc_pkg::OFS_CMD, 1'b1, {24'h0, c[i]});
    repeat (2) @(posedge pclk);
  endtask : cmd
  // talk at once after a query
  task automatic talk(output string t);
    t = "";
    apb(mrc_pkg::OFS_TALK, 1'b1, 32'h0);
    repeat (40) begin
      apb(mrc_pkg::OFS_TXD, 1'b0, 32'h0);
      if (rd[mrc_pkg::TXD_VLD] !== 1'b1) break;
      t = $sformatf("%s%c", t, rd[7:0]);
    end
  endtask : talk
  // value, aux word, commands, optional bus or key trigger pulse, then the reply
  task automatic reading(input string c, input logic [31:0] v, input logic [17:0] x,
      input logic [1:0] bus_trigger_event, input string e);
    apb(mrc_pkg::OFS_MVAL, 1'b1, v);
    apb(mrc_pkg::OFS_MAUX, 1'b1, {14'h0, x});
    cmd(c);
    if (bus_trigger_event != 2'h0) begin
      bus_trig <= bus_trigger_event[0];
      key_pin <= bus_trigger_event[1];
      repeat (4) @(posedge pclk);
      bus_trig <= 1'b0;
      key_pin <= 1'b0;
    end
    repeat (50) begin
      apb(mrc_pkg::OFS_STAT, 1'b0, 32'h0);
      if (rd[mrc_pkg::ST_RDY] === 1'b1) break;
    end
    talk(s);
    chk_s("reading", e, s);
  endtask : reading
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(mrc_pkg::OFS_STAT, 1'b0, 32'h0);
    chk("status rst", 32'h0, rd);
    apb(8'h18, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    cmd("PY");
    chk("prefix", 32'h1, {31'h0, prefix_on});
    cmd("T3VT6");
    chk("trig", 32'h2, {30'h0, trig_mode});
    cmd("U1");
    talk(s);
    chk_s("err word", "1000ICMICOFL\r\n", s);
    apb(mrc_pkg::OFS_STAT, 1'b0, 32'h0);
    chk("status clr", 32'h40, rd);
    cmd("J0");
    repeat (10) @(posedge pclk);
    cmd("U1");
    talk(s);
    chk_s("test word", "1000VCMVCOPS\r\n", s);
    cmd("WABCDEF U2");
    talk(s);
    chk_s("rev word", "1000ABCDEF0101GT\r\n", s);
    reading("", 32'h31323334, {2'h2, 8'h57, 8'h30}, 2'h1, "OFC199.9W\r\n");
    reading("RCYO", 32'h31323334, {2'h1, 8'h57, 8'h30}, 2'h1, "URC .000W\r");
    reading("PNYN", 32'h302E3132, {2'h0, 8'h57, 8'h33}, 2'h1, "0.123W");
    reading("PYT5FD", 32'h302E3132, {2'h0, 8'h57, 8'h33}, 2'h0, "NFD0.123W");
    panel_load <= 1'b1;
    @(posedge pclk);
    panel_load <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("panel pfx", 32'h0, {31'h0, prefix_on});
    cmd("U0");
    chk("restored", 32'h1, {31'h0, prefix_on});
    chk("mach trig", 32'h3, {30'h0, trig_mode});
    chk("mach meas", 32'h1, {29'h0, meas_type});
    chk("mach term", 32'h2, {30'h0, term_mode});
    talk(s);
    chk_s("mach word", "1000Y5FDN", s);
    reading("T1", 32'h31323334, {2'h0, 8'h57, 8'h35}, 2'h2, "NFD12345W");
    cmd("J0");
    repeat (10) @(posedge pclk);
    st_pass_in <= 1'b0;
    cmd("J0");
    repeat (10) @(posedge pclk);
    cmd("U1");
    talk(s);
    chk_s("fail word", "1000VCMVCOFL", s);
    complete_run();
  end
endmodule : testbench
